// file: verilog/cal_companding_loopback.sv
// Purpose: Record-side compression, playback-side expansion and digital loopback
// Assumes: All inputs are on sys_clk; control words arrive already deserialised
// Notes: Each path has one cycle of latency from input strobe to output strobe
//
// How it works
// - Mu-law and A-law are each selectable on record and playback independently.
// - Playback select bits 4:3 and record select bits 2:1 mean off, reserved, mu-law, A-law.
// - The packed byte setting forces the interface word length to eight bits.
// - With bit 6 set the playback interface word is sent straight out as the record word.
// - With bit 0 set the record linear sample is fed straight to the playback datapath.
// - Mu-law codes have all bits inverted and A-law codes only their even bits.
// - A companded byte sits in the top eight bits of the interface word.
// - Compression maps 14-bit linear for mu-law or 13-bit linear for A-law to eight bits.
// - The linear range is split into eight segments with finer steps near zero.
// - The code holds sign in bit 7, segment in bits 6:4 and mantissa in bits 3:0.
// - Segments follow the piecewise G.711 laws with mu of 255 and A of 87.6.
`timescale 1ns/1ns
`default_nettype none
module cal_companding_loopback
	import cal_pkg::*;
#(
	parameter int IFACE_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire cal_ctrl_wr_type ctrl_in,
	output logic [15:0] ctrl_rdata,
	input wire logic [1:0] iface_word_length,
	output logic [5:0] word_len_bits,
	input wire cal_word_type rec_lin_in,
	output logic [IFACE_W-1:0] rec_iface_data,
	output logic rec_iface_valid,
	input wire logic [IFACE_W-1:0] play_iface_data,
	input wire logic play_iface_valid,
	output cal_word_type play_lin_out
);
	if (IFACE_W < 16) begin : g_width_check
		$error("IFACE_W must be at least 16");
	end

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] rdata;
		logic [5:0] wlen;
		logic [IFACE_W-1:0] rec_data;
		logic rec_valid;
		cal_word_type play;
	} cal_state_type;

	cal_state_type state_reg;
	cal_state_type state_next;

	function automatic logic [7:0] cal_mu_compress(input logic [CAL_LIN_W-1:0] s);
		logic [13:0] p;
		logic neg;
		logic [13:0] mag;
		logic [2:0] seg;
		logic [13:0] sh;
		p = s[CAL_LIN_W-1 -: 14];
		neg = p[13];
		mag = neg ? 14'(~p + 14'h0001) : p;
		if (mag > CAL_MU_CLIP) begin
			mag = CAL_MU_CLIP;
		end
		mag = mag + CAL_MU_BIAS;
		seg = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i+5]) begin
				seg = 3'(i);
			end
		end
		sh = mag >> ({1'b0, seg} + 4'h1);
		return {neg, seg, sh[3:0]} ^ CAL_MU_INV;
	endfunction

	function automatic logic [7:0] cal_a_compress(input logic [CAL_LIN_W-1:0] s);
		logic [12:0] p;
		logic neg;
		logic [12:0] mag;
		logic [2:0] seg;
		logic [12:0] sh;
		p = s[CAL_LIN_W-1 -: 13];
		neg = p[12];
		mag = neg ? ~p : p;
		seg = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i+4]) begin
				seg = 3'(i);
			end
		end
		sh = (seg < 3'h2) ? (mag >> 1) : (mag >> seg);
		return {~neg, seg, sh[3:0]} ^ CAL_A_INV;
	endfunction

	function automatic logic [CAL_LIN_W-1:0] cal_mu_expand(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] t;
		u = c ^ CAL_MU_INV;
		t = (16'({u[3:0], 3'h0}) + CAL_MU_EXP_BIAS) << u[6:4];
		return u[7] ? (CAL_MU_EXP_BIAS - t) : (t - CAL_MU_EXP_BIAS);
	endfunction

	function automatic logic [CAL_LIN_W-1:0] cal_a_expand(input logic [7:0] c);
		logic [7:0] a;
		logic [15:0] t;
		a = c ^ CAL_A_INV;
		t = 16'({a[3:0], 4'h0});
		if (a[6:4] == 3'h0) begin
			t = t + CAL_A_SEG0_ADD;
		end else begin
			t = (t + CAL_A_SEGN_ADD) << (a[6:4] - 3'h1);
		end
		return a[7] ? t : (16'h0000 - t);
	endfunction

	function automatic logic [1:0] cal_law(input logic [15:0] r, input int lsb);
		return r[lsb +: 2];
	endfunction

	logic [1:0] rec_law;
	logic [1:0] play_law;
	logic [7:0] rec_code;
	logic [CAL_LIN_W-1:0] play_lin;

	always_comb begin
		state_next = state_reg;
		rec_law = cal_law(state_reg.ctrl, CAL_REC_COMP_LSB);
		play_law = cal_law(state_reg.ctrl, CAL_PLAY_COMP_LSB);
		rec_code = 8'h00;
		play_lin = play_iface_data[IFACE_W-1 -: CAL_LIN_W];
		// Control register write
		if (ctrl_in.wr && ctrl_in.addr == CAL_CTRL_OFFSET) begin
			state_next.ctrl = ctrl_in.data & CAL_CTRL_USED;
		end
		state_next.rdata = (ctrl_in.addr == CAL_CTRL_OFFSET) ? state_reg.ctrl : 16'h0000;
		if (state_reg.ctrl[CAL_PACKED_BIT]) begin
			state_next.wlen = CAL_WL_PACKED;
		end else begin
			case (iface_word_length)
				2'h0: state_next.wlen = CAL_WL_16;
				2'h1: state_next.wlen = CAL_WL_20;
				2'h2: state_next.wlen = CAL_WL_24;
				default: state_next.wlen = CAL_WL_32;
			endcase
		end
		case (rec_law)
			CAL_LAW_MU: rec_code = cal_mu_compress(rec_lin_in.data);
			CAL_LAW_A: rec_code = cal_a_compress(rec_lin_in.data);
			default: rec_code = 8'h00;
		endcase
		if (state_reg.ctrl[CAL_PLAY_LOOP_BIT]) begin
			state_next.rec_valid = play_iface_valid;
			state_next.rec_data = play_iface_valid ? play_iface_data : state_reg.rec_data;
		end else begin
			state_next.rec_valid = rec_lin_in.valid;
			if (rec_lin_in.valid) begin
				if (rec_law == CAL_LAW_MU || rec_law == CAL_LAW_A) begin
					state_next.rec_data = {rec_code, {(IFACE_W-8){1'b0}}};
				end else begin
					state_next.rec_data = IFACE_W'(rec_lin_in.data) << (IFACE_W - CAL_LIN_W);
				end
			end
		end
		case (play_law)
			CAL_LAW_MU: play_lin = cal_mu_expand(play_iface_data[IFACE_W-1 -: 8]);
			CAL_LAW_A: play_lin = cal_a_expand(play_iface_data[IFACE_W-1 -: 8]);
			default: play_lin = play_iface_data[IFACE_W-1 -: CAL_LIN_W];
		endcase
		if (state_reg.ctrl[CAL_REC_LOOP_BIT]) begin
			state_next.play.valid = rec_lin_in.valid;
			if (rec_lin_in.valid) begin
				state_next.play.data = rec_lin_in.data;
			end
		end else begin
			state_next.play.valid = play_iface_valid;
			if (play_iface_valid) begin
				state_next.play.data = play_lin;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.ctrl <= CAL_CTRL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ctrl_rdata = state_reg.rdata;
	assign word_len_bits = state_reg.wlen;
	assign rec_iface_data = state_reg.rec_data;
	assign rec_iface_valid = state_reg.rec_valid;
	assign play_lin_out = state_reg.play;

	logic [15:0] cr;
	assign cr = state_reg.ctrl;

	sequence cal_ctrl_write_s;
		ctrl_in.wr && ctrl_in.addr == CAL_CTRL_OFFSET;
	endsequence

	sequence cal_rec_plain_s;
		rec_lin_in.valid && !cr[CAL_PLAY_LOOP_BIT];
	endsequence

	sequence cal_play_plain_s;
		play_iface_valid && !cr[CAL_REC_LOOP_BIT];
	endsequence

	ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_ctrl_write_s |=> cr == ($past(ctrl_in.data) & CAL_CTRL_USED))
		else $error("control write not stored");

	packed_len_a: assert property (@(posedge sys_clk) disable iff (rst)
		cr[CAL_PACKED_BIT] |=> word_len_bits == CAL_WL_PACKED)
		else $error("packed mode word length not eight");

	play_loop_a: assert property (@(posedge sys_clk) disable iff (rst)
		cr[CAL_PLAY_LOOP_BIT] && play_iface_valid
		|=> rec_iface_valid && rec_iface_data == $past(play_iface_data))
		else $error("playback loopback word lost");

	rec_loop_a: assert property (@(posedge sys_clk) disable iff (rst)
		cr[CAL_REC_LOOP_BIT] && rec_lin_in.valid
		|=> play_lin_out.valid && play_lin_out.data == $past(rec_lin_in.data))
		else $error("record loopback sample lost");

	mu_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_rec_plain_s ##0 (rec_law == CAL_LAW_MU && rec_lin_in.data == 16'h0000)
		|=> rec_iface_data[IFACE_W-1 -: 8] == 8'hff)
		else $error("mu-law zero code wrong");

	a_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_rec_plain_s ##0 (rec_law == CAL_LAW_A && rec_lin_in.data == 16'h0000)
		|=> rec_iface_data[IFACE_W-1 -: 8] == 8'hd5)
		else $error("A-law zero code wrong");

	code_msb_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_rec_plain_s ##0 rec_law[1] |=> rec_iface_data[IFACE_W-9:0] == '0)
		else $error("companded code not in top byte");

	mu_round_a: assert property (@(posedge sys_clk) disable iff (rst)
		play_iface_valid && !cr[CAL_REC_LOOP_BIT] && play_law == CAL_LAW_MU
		&& play_iface_data[IFACE_W-1 -: 8] == 8'h80
		|=> play_lin_out.valid && play_lin_out.data == 16'h7d7c)
		else $error("mu-law expansion of full scale wrong");

	reset_off_a: assert property (@(posedge sys_clk)
		$fell(rst) |-> cr == CAL_CTRL_RESET)
		else $error("control not cleared by reset");

	reset_quiet_a: assert property (@(posedge sys_clk)
		$fell(rst) |-> !rec_iface_valid && !play_lin_out.valid)
		else $error("output strobe active after reset");

	ctrl_other_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_in.wr && ctrl_in.addr != CAL_CTRL_OFFSET |=> $stable(cr))
		else $error("write to other address changed control");

	ctrl_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_in.addr == CAL_CTRL_OFFSET |=> ctrl_rdata == $past(cr))
		else $error("control readback wrong");

	other_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_in.addr != CAL_CTRL_OFFSET |=> ctrl_rdata == 16'h0000)
		else $error("readback of other address not zero");

	wlen_long_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cr[CAL_PACKED_BIT] && iface_word_length == 2'h3 |=> word_len_bits == CAL_WL_32)
		else $error("long word length wrong");

	wlen_short_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cr[CAL_PACKED_BIT] && iface_word_length == 2'h0 |=> word_len_bits == CAL_WL_16)
		else $error("short word length wrong");

	rec_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_rec_plain_s ##0 !rec_law[1]
		|=> rec_iface_data[IFACE_W-1 -: CAL_LIN_W] == $past(rec_lin_in.data))
		else $error("uncompanded record word altered");

	play_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_play_plain_s ##0 !play_law[1]
		|=> play_lin_out.data == $past(play_iface_data[IFACE_W-1 -: CAL_LIN_W]))
		else $error("unexpanded playback word altered");

	a_round_a: assert property (@(posedge sys_clk) disable iff (rst)
		cal_play_plain_s ##0 (play_law == CAL_LAW_A
		&& play_iface_data[IFACE_W-1 -: 8] == 8'hd5)
		|=> play_lin_out.valid && play_lin_out.data == 16'h0008)
		else $error("A-law expansion of smallest code wrong");

	rec_valid_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cr[CAL_PLAY_LOOP_BIT] |=> rec_iface_valid == $past(rec_lin_in.valid))
		else $error("record strobe not following sample strobe");

	play_valid_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cr[CAL_REC_LOOP_BIT] |=> play_lin_out.valid == $past(play_iface_valid))
		else $error("playback strobe not following interface strobe");
endmodule // cal_companding_loopback
`default_nettype wire

// file: verilog/cal_pkg.sv
// Purpose: Shared constants and carriers for the companding and loopback block
// Assumes: 16-bit signed linear samples, 16-bit control register
// Notes: Law codes and inversion masks follow the companded word layout
package cal_pkg;
	localparam int CAL_LIN_W = 16;
	localparam logic [6:0] CAL_CTRL_OFFSET = 7'h05;
	localparam logic [15:0] CAL_CTRL_RESET = 16'h0000;
	localparam int CAL_REC_LOOP_BIT = 0;
	localparam int CAL_REC_COMP_LSB = 1;
	localparam int CAL_PLAY_COMP_LSB = 3;
	localparam int CAL_PACKED_BIT = 5;
	localparam int CAL_PLAY_LOOP_BIT = 6;
	localparam logic [15:0] CAL_CTRL_USED = 16'h007f;
	localparam logic [1:0] CAL_LAW_OFF = 2'h0;
	localparam logic [1:0] CAL_LAW_RSVD = 2'h1;
	localparam logic [1:0] CAL_LAW_MU = 2'h2;
	localparam logic [1:0] CAL_LAW_A = 2'h3;
	localparam logic [7:0] CAL_MU_INV = 8'hff;
	localparam logic [7:0] CAL_A_INV = 8'h55;
	localparam logic [13:0] CAL_MU_CLIP = 14'h1fde;
	localparam logic [13:0] CAL_MU_BIAS = 14'h0021;
	localparam logic [15:0] CAL_MU_EXP_BIAS = 16'h0084;
	localparam logic [15:0] CAL_A_SEG0_ADD = 16'h0008;
	localparam logic [15:0] CAL_A_SEGN_ADD = 16'h0108;
	localparam logic [5:0] CAL_WL_PACKED = 6'h08;
	localparam logic [5:0] CAL_WL_16 = 6'h10;
	localparam logic [5:0] CAL_WL_20 = 6'h14;
	localparam logic [5:0] CAL_WL_24 = 6'h18;
	localparam logic [5:0] CAL_WL_32 = 6'h20;

	typedef struct packed {
		logic [6:0] addr;
		logic [15:0] data;
		logic wr;
	} cal_ctrl_wr_type;

	typedef struct packed {
		logic [CAL_LIN_W-1:0] data;
		logic valid;
	} cal_word_type;
endpackage

// file: tb/cal_host_model.sv
// Purpose: Host side that sends playback interface words
// Assumes: Called from the bench at rising edges
// Notes: A released data line shows the inverse of the value it held the cycle before
`timescale 1ns/1ns
`default_nettype none
module cal_host_model (
	output logic [15:0] play_iface_data,
	output logic play_iface_valid
);
	initial play_iface_data = 16'h0000;
	initial play_iface_valid = 1'b0;
	// One word with strobe, or release
	task automatic send(input logic [15:0] d, input logic v);
		play_iface_data <= v ? d : ~play_iface_data;
		play_iface_valid <= v;
	endtask
endmodule // cal_host_model
`default_nettype wire

// file: tb/test_audio_companding_loopback.sv
// Purpose: Self-checking bench for the companding and loopback block
// Assumes: 50 MHz sys_clk, inputs driven at rising edges
// Notes: Expected words are queued and matched by a monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module test_audio_companding_loopback
	import cal_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	cal_ctrl_wr_type ctrl_in = '{CAL_CTRL_OFFSET, 16'h0000, 1'b0};
	logic [1:0] iface_word_length = 2'h0;
	cal_word_type rec_lin_in = '{16'h0000, 1'b0};
	cal_word_type play_lin_out;
	logic [15:0] ctrl_rdata, rec_iface_data, play_iface_data, re, pe;
	logic [5:0] word_len_bits;
	logic rec_iface_valid, play_iface_valid;
	logic [15:0] rq[$], pq[$];
	int n_fail = 0;
	int checked = 0;
	always #10 sys_clk = ~sys_clk;
	cal_companding_loopback u_cal_companding_loopback (.sys_clk(sys_clk), .rst(rst),
		.ctrl_in(ctrl_in), .ctrl_rdata(ctrl_rdata), .iface_word_length(iface_word_length),
		.word_len_bits(word_len_bits), .rec_lin_in(rec_lin_in),
		.rec_iface_data(rec_iface_data), .rec_iface_valid(rec_iface_valid),
		.play_iface_data(play_iface_data), .play_iface_valid(play_iface_valid),
		.play_lin_out(play_lin_out));
	cal_host_model u_cal_host_model (.play_iface_data(play_iface_data),
		.play_iface_valid(play_iface_valid));
	function automatic logic [15:0] enc(input logic [1:0] law, input logic [15:0] s);
		int v, m, g;
		v = (law == 2'h3) ? int'($signed(s[15:3])) : int'($signed(s[15:2]));
		m = (v < 0) ? -v : v;
		g = 0;
		if (law == 2'h2) begin
			if (m > 8158) m = 8158;
			m = m + 33;
			for (int i = 0; i < 7; i++) if (m >= (64 << i)) g = i + 1;
			return {{1'b0, 3'(g), 4'(m >> (g + 1))} ^ ((v < 0) ? 8'h7f : 8'hff), 8'h00};
		end
		if (law == 2'h3) begin
			if (v < 0) m = m - 1;
			for (int i = 0; i < 7; i++) if (m >= (32 << i)) g = i + 1;
			return {{1'b0, 3'(g), 4'(m >> ((g < 2) ? 1 : g))} ^ ((v < 0) ? 8'h55 : 8'hd5), 8'h00};
		end
		return s;
	endfunction
	function automatic logic [15:0] dec(input logic [1:0] law, input logic [15:0] w);
		logic [7:0] u;
		int t;
		if (law == 2'h2) begin
			u = ~w[15:8];
			t = ((32'(u[3:0]) << 3) + 132) << u[6:4];
			return u[7] ? 16'(132 - t) : 16'(t - 132);
		end
		if (law == 2'h3) begin
			u = w[15:8] ^ 8'h55;
			t = (32'(u[3:0]) << 4) + ((u[6:4] == 3'h0) ? 8 : 264);
			if (u[6:4] > 3'h1) t = t << (u[6:4] - 1);
			return u[7] ? 16'(t) : 16'(-t);
		end
		return w;
	endfunction
	function automatic logic [5:0] wl_exp(input logic pk, input logic [1:0] w);
		if (pk) return CAL_WL_PACKED;
		case (w)
			2'h0: return CAL_WL_16;
			2'h1: return CAL_WL_20;
			2'h2: return CAL_WL_24;
			default: return CAL_WL_32;
		endcase
	endfunction
	task automatic step(input logic [15:0] r, input logic v, input logic [15:0] p);
		rec_lin_in <= '{v ? r : ~rec_lin_in.data, v};
		u_cal_host_model.send(p, v);
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [15:0] er);
		ctrl_in <= '{a, d, 1'b1};
		@(posedge sys_clk);
		ctrl_in <= '{CAL_CTRL_OFFSET, ~d, 1'b0};
		@(posedge sys_clk);
		#1;
		`CHK(ctrl_rdata, er)
		`CHK(word_len_bits, wl_exp(er[5], iface_word_length))
		@(posedge sys_clk);
	endtask
	task automatic burst(input int c, input bit lb);
		logic [15:0] r, p;
		for (int k = 0; k < 12; k++) begin
			r = (k == 0) ? 16'h0000 : (k == 1) ? 16'h8000 : (k == 2) ? 16'h7fff : 16'($urandom);
			p = (k == 0) ? 16'h8000 : (k == 1) ? 16'hd500 : 16'($urandom);
			rq.push_back(lb ? p : enc(2'(c), r));
			pq.push_back(lb ? r : dec(2'(c >> 2), p));
			step(r, 1'b1, p);
		end
		repeat (3) step(r, 1'b0, p);
	endtask
	task automatic give_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if (rec_iface_valid === 1'b1) begin
			re = (rq.size() > 0) ? rq.pop_front() : ~rec_iface_data;
			`CHK(rec_iface_data, re)
		end
		if (play_lin_out.valid === 1'b1) begin
			pe = (pq.size() > 0) ? pq.pop_front() : ~play_lin_out.data;
			`CHK(play_lin_out.data, pe)
		end
	end
	initial begin
		#400000;
		n_fail++;
		give_verdict();
	end
	initial begin
		int s;
		s = $urandom(32'h64ad);
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(ctrl_rdata, 16'h0000)
		`CHK(word_len_bits, 6'h10)
		@(posedge sys_clk);
		for (int c = 0; c < 16; c++) begin
			wr(CAL_CTRL_OFFSET, 16'(c << 1), 16'(c << 1));
			burst(c, 1'b0);
		end
		for (int w = 0; w < 8; w++) begin
			iface_word_length <= 2'(w);
			wr(CAL_CTRL_OFFSET, 16'((w & 4) << 3), 16'((w & 4) << 3));
		end
		wr(CAL_CTRL_OFFSET, 16'hffff, CAL_CTRL_USED);
		wr(7'h04, 16'h0000, CAL_CTRL_USED);
		wr(CAL_CTRL_OFFSET, 16'h0055, 16'h0055);
		burst(0, 1'b1);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(ctrl_rdata, 16'h0000)
		`CHK(rq.size() + pq.size(), 0)
		give_verdict();
	end
endmodule // test_audio_companding_loopback
`default_nettype wire
